//--- shared/acit_map.svh
/*
 holds: named offsets, field positions, reset values and codes for the
 amplifier control target.
 assumes: included by bare name from the design files.
*/
// Contract
// - mode bit 3 picks internal/external gain
// - mode bit 2 picks fixed 0dB/adjustable volume
// - mode bit 1 set mutes outputs
// - mode bit 0 clear shuts device down
// - strap low two-wire, high SPI
// - address 110110, select pin, then 0
// - start condition makes target compare address
// - bits MSB first, sampled on SCL rise
// - matched address acknowledged by pulling SDA
// - every data byte acknowledged with SDA low
// - further bytes accepted until transfer ends
// - stop condition returns target to idle
// - SCL input only, SDA pull-down only
// - bridged if detect low and override clear
// - beep forces bridged path regardless of settings
`ifndef ACIT_MAP_SVH
`define ACIT_MAP_SVH
// ****************************************
// register offsets
// ****************************************
`define ACIT_OFS_MODE 4'h0
`define ACIT_OFS_VOL 4'h4
`define ACIT_OFS_STAT 4'h8
`define ACIT_OFS_CTRL 4'hC
// ****************************************
// fields and reset values
// ****************************************
`define ACIT_MODE_OVR 4
`define ACIT_MODE_GAIN 3
`define ACIT_MODE_VOLM 2
`define ACIT_MODE_MUTE 1
`define ACIT_MODE_ACT 0
`define ACIT_MODE_RST 5'h00
`define ACIT_VOL_RST 5'h00
`define ACIT_CTRL_RST 1'h1
`define ACIT_ST_BRIDGED 0
`define ACIT_ST_SINGLE 1
`define ACIT_ST_BEEP 2
`define ACIT_ST_IDSEL 3
`define ACIT_ST_SPI 4
`define ACIT_ST_BUSY 5
// ****************************************
// serial link codes
// ****************************************
`define ACIT_ADDR_PREFIX 6'h36
`define ACIT_BYTE_BITS 4'h8
`define ACIT_PFX_MODE 3'h0
`define ACIT_PFX_VOL 3'h4
`define ACIT_RESP_OKAY 2'h0
`define ACIT_RESP_SLVERR 2'h2
`endif

//--- shared/acit_pkg.sv
/*
 holds: types shared by the amplifier control target.
 assumes: compiled before the design modules.
*/
package acit_pkg;
  // ****************************************
  // serial target states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_DATA,
    ST_DATA_ACK,
    ST_SKIP
  } acit_state_type;
endpackage : acit_pkg

//--- rtl/acit_line_watch.sv
/*
 holds: bus-line watcher, turns sampled SCL/SDA into event pulses.
 assumes: line inputs already synchronous to aclk.
*/
`timescale 1ns/1ps
module acit_line_watch (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_s,
  output logic start_p,
  output logic stop_p,
  output logic scl_rise_p,
  output logic scl_fall_p
);
  logic scl_q, sda_q;
  // ****************************************
  // edge and condition decode
  // ****************************************
  // start/stop need SCL high on both samples, so a data change is not one
  wire start_d = scl_q & scl_i & sda_q & ~sda_i;
  wire stop_d = scl_q & scl_i & ~sda_q & sda_i;
  // lines idle high after reset so no false edge at release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_s <= 1'b1;
      start_p <= 1'b0;
      stop_p <= 1'b0;
      scl_rise_p <= 1'b0;
      scl_fall_p <= 1'b0;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      sda_s <= sda_i;
      start_p <= start_d;
      stop_p <= stop_d;
      scl_rise_p <= ~scl_q & scl_i;
      scl_fall_p <= scl_q & ~scl_i;
    end
  end
endmodule : acit_line_watch

//--- rtl/acit_target.sv
/*
 holds: two-wire control target of the amplifier, its control outputs
 and an AXI4-Lite register slave.
 assumes: one clock; pins synchronous; SDA wire resolved outside from
 sda_oe_n; one AXI write and one read at a time.
*/
`timescale 1ns/1ps
`include "acit_map.svh"
module acit_target #(
  parameter int ADDR_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic address_select_pin,
  input wire logic interface_select_pin,
  input wire logic headphone_detect_pin,
  input wire logic beep_detect_pin,
  output logic gain_external,
  output logic volume_adjustable,
  output logic audio_mute,
  output logic device_active,
  output logic [4:0] volume_level,
  output logic bridged_output,
  output logic single_ended_output
);
  import acit_pkg::*;

  // ****************************************
  // line events
  // ****************************************
  logic sda_s, start_p, stop_p, rise_p, fall_p;
  acit_line_watch u_watch (
    .aclk(aclk),
    .aresetn(aresetn),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_s(sda_s),
    .start_p(start_p),
    .stop_p(stop_p),
    .scl_rise_p(rise_p),
    .scl_fall_p(fall_p)
  );

  // ****************************************
  // straps, caught once after reset release
  // ****************************************
  logic strap_ok_q, id_sel_q, spi_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_ok_q <= 1'b0;
      id_sel_q <= 1'b0;
      spi_q <= 1'b0;
    end else if (!strap_ok_q) begin
      strap_ok_q <= 1'b1;
      id_sel_q <= address_select_pin;
      spi_q <= interface_select_pin;
    end
  end

  // ****************************************
  // serial target state machine
  // ****************************************
  acit_state_type state_q, state_d;
  logic [7:0] shift_q;
  logic [3:0] cnt_q;
  logic [4:0] mode_q, vol_q;
  logic ctrl_en_q;
  // spi strap leaves the two-wire target deaf; that framing lives elsewhere
  wire listen = strap_ok_q & ~spi_q & ctrl_en_q;
  wire byte_done = cnt_q == `ACIT_BYTE_BITS;
  wire [7:0] own_addr = {`ACIT_ADDR_PREFIX, id_sel_q, 1'b0};
  wire addr_match = shift_q == own_addr;
  wire in_ack = state_q == ST_ADDR_ACK || state_q == ST_DATA_ACK;
  wire in_bits = state_q == ST_ADDR || state_q == ST_DATA;
  wire line_evt = start_p | stop_p;
  wire commit_p = fall_p & ~line_evt & state_q == ST_DATA_ACK;
  wire [2:0] prefix = shift_q[7:5];
  wire drive_d = state_d == ST_ADDR_ACK || state_d == ST_DATA_ACK;

  // next state; a dropped listen wins, then start and stop override the case, a start mid-frame
  // is a repeated start
  always_comb begin
    state_d = state_q;
    if (!listen) begin
      state_d = ST_IDLE;
    end else if (start_p) begin
      state_d = ST_ADDR;
    end else if (stop_p) begin
      state_d = ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: state_d = ST_IDLE;
        ST_ADDR: begin
          if (fall_p && byte_done) begin
            state_d = addr_match ? ST_ADDR_ACK : ST_SKIP;
          end
        end
        ST_ADDR_ACK: begin
          if (fall_p) begin
            state_d = ST_DATA;
          end
        end
        ST_DATA: begin
          if (fall_p && byte_done) begin
            state_d = ST_DATA_ACK;
          end
        end
        ST_DATA_ACK: begin
          if (fall_p) begin
            state_d = ST_DATA;
          end
        end
        ST_SKIP: state_d = ST_SKIP;
      endcase
    end
  end

  // state and pull-down enable; SDA is only ever pulled low, SCL never driven
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      sda_oe_n <= 1'b1;
      sda_o <= 1'b0;
    end else begin
      state_q <= state_d;
      sda_oe_n <= ~drive_d;
      sda_o <= 1'b0;
    end
  end

  // bit shifter, sampled on SCL rise, MSB first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_q <= 8'h00;
      cnt_q <= 4'h0;
    end else if (start_p || (fall_p && in_ack)) begin
      cnt_q <= 4'h0;
    end else if (rise_p && in_bits && !byte_done) begin
      shift_q <= {shift_q[6:0], sda_s};
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  logic aw_have_q, w_have_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [31:0] wdat_q;
  logic wlane_q;
  wire aw_take = awvalid & awready;
  wire w_take = wvalid & wready;
  wire do_write = aw_have_q & w_have_q & ~bvalid;
  wire [3:0] wofs = waddr_q[3:0];
  wire wr_mode = do_write & wlane_q & wofs == `ACIT_OFS_MODE;
  wire wr_vol = do_write & wlane_q & wofs == `ACIT_OFS_VOL;
  wire wr_ctrl = do_write & wlane_q & wofs == `ACIT_OFS_CTRL;
  wire w_mapped = wofs == `ACIT_OFS_MODE || wofs == `ACIT_OFS_VOL ||
                  wofs == `ACIT_OFS_STAT || wofs == `ACIT_OFS_CTRL;

  // ready is a one-cycle registered pulse; address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= '0;
      wdat_q <= 32'h0;
      wlane_q <= 1'b0;
    end else begin
      awready <= awvalid & ~awready & ~aw_have_q & ~bvalid;
      wready <= wvalid & ~wready & ~w_have_q & ~bvalid;
      if (aw_take) begin
        aw_have_q <= 1'b1;
        waddr_q <= awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdat_q <= wdata;
        wlane_q <= wstrb[0];
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // response after both halves; unmapped offsets answer slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `ACIT_RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= w_mapped ? `ACIT_RESP_OKAY : `ACIT_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ****************************************
  // control settings
  // ****************************************
  // a serial commit wins over a software write in the same cycle,
  // the bus is the control path the board was built around
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= `ACIT_MODE_RST;
      vol_q <= `ACIT_VOL_RST;
      ctrl_en_q <= `ACIT_CTRL_RST;
    end else begin
      if (commit_p && prefix == `ACIT_PFX_MODE) begin
        mode_q <= shift_q[4:0];
      end else if (wr_mode) begin
        mode_q <= wdat_q[4:0];
      end
      if (commit_p && prefix == `ACIT_PFX_VOL) begin
        vol_q <= shift_q[4:0];
      end else if (wr_vol) begin
        vol_q <= wdat_q[4:0];
      end
      if (wr_ctrl) begin
        ctrl_en_q <= wdat_q[0];
      end
    end
  end

  // ****************************************
  // amplifier control outputs
  // ****************************************
  wire hp_bridged = ~headphone_detect_pin & ~mode_q[`ACIT_MODE_OVR];
  // a beep takes the bridged stage whatever mute and headphone say
  wire bridged_d = hp_bridged | beep_detect_pin;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_external <= 1'b0;
      volume_adjustable <= 1'b0;
      audio_mute <= 1'b0;
      device_active <= 1'b0;
      volume_level <= `ACIT_VOL_RST;
      bridged_output <= 1'b0;
      single_ended_output <= 1'b0;
    end else begin
      gain_external <= mode_q[`ACIT_MODE_GAIN];
      volume_adjustable <= mode_q[`ACIT_MODE_VOLM];
      audio_mute <= mode_q[`ACIT_MODE_MUTE];
      device_active <= mode_q[`ACIT_MODE_ACT];
      volume_level <= vol_q;
      bridged_output <= bridged_d;
      single_ended_output <= ~bridged_d;
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  wire [3:0] rofs = araddr[3:0];
  logic [31:0] stat_w;
  always_comb begin
    stat_w = 32'h0;
    stat_w[`ACIT_ST_BRIDGED] = bridged_output;
    stat_w[`ACIT_ST_SINGLE] = single_ended_output;
    stat_w[`ACIT_ST_BEEP] = beep_detect_pin;
    stat_w[`ACIT_ST_IDSEL] = id_sel_q;
    stat_w[`ACIT_ST_SPI] = spi_q;
    stat_w[`ACIT_ST_BUSY] = state_q != ST_IDLE;
  end
  wire r_mapped = rofs == `ACIT_OFS_MODE || rofs == `ACIT_OFS_VOL ||
                  rofs == `ACIT_OFS_STAT || rofs == `ACIT_OFS_CTRL;
  wire [31:0] rmux = rofs == `ACIT_OFS_MODE ? {27'h0, mode_q} :
                     rofs == `ACIT_OFS_VOL ? {27'h0, vol_q} :
                     rofs == `ACIT_OFS_STAT ? stat_w :
                     rofs == `ACIT_OFS_CTRL ? {31'h0, ctrl_en_q} : 32'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `ACIT_RESP_OKAY;
    end else begin
      arready <= arvalid & ~arready & ~rvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rmux;
        rresp <= r_mapped ? `ACIT_RESP_OKAY : `ACIT_RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  wire mode_cmt = commit_p && prefix == `ACIT_PFX_MODE;
  gain_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_cmt |-> ##2 gain_external == $past(shift_q[`ACIT_MODE_GAIN], 2))
    else $error("gain source not taken from mode byte");
  vol_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_cmt |-> ##2 volume_adjustable == $past(shift_q[`ACIT_MODE_VOLM], 2))
    else $error("volume mode not taken from mode byte");
  mute_ctl_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_cmt |-> ##2 audio_mute == $past(shift_q[`ACIT_MODE_MUTE], 2))
    else $error("mute not taken from mode byte");
  power_ctl_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_cmt |-> ##2 device_active == $past(shift_q[`ACIT_MODE_ACT], 2))
    else $error("power state not taken from mode byte");
  spi_deaf_a: assert property (@(posedge aclk) disable iff (!aresetn)
    spi_q && $past(spi_q) |-> sda_oe_n && state_q == ST_IDLE)
    else $error("two-wire target active in spi mode");
  start_cmp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start_p && listen |=> state_q == ST_ADDR && cnt_q == 4'h0)
    else $error("start did not open address phase");
  bit_sample_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rise_p && in_bits && !byte_done && !start_p |=> shift_q[0] == $past(sda_s))
    else $error("bit not sampled on clock rise");
  addr_ack_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_ADDR && fall_p && byte_done && listen && !line_evt
    |=> sda_oe_n == !$past(addr_match))
    else $error("address acknowledge wrong");
  data_ack_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_DATA && fall_p && byte_done && listen && !line_evt
    |=> !sda_oe_n && state_q == ST_DATA_ACK)
    else $error("data byte not acknowledged");
  next_byte_a: assert property (@(posedge aclk) disable iff (!aresetn)
    commit_p && listen |=> state_q == ST_DATA && sda_oe_n && cnt_q == 4'h0)
    else $error("target not ready for next byte");
  stop_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_p && !start_p |=> state_q == ST_IDLE && sda_oe_n)
    else $error("stop did not return to idle");
  sda_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !sda_oe_n |-> in_ack && sda_o == 1'b0)
    else $error("sda driven outside acknowledge");
  hp_cfg_a: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn && !beep_detect_pin |=> bridged_output == $past(hp_bridged) &&
    single_ended_output == !bridged_output)
    else $error("output stage configuration wrong");
  beep_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn && beep_detect_pin |=> bridged_output && !single_ended_output)
    else $error("beep not routed to bridged stage");
  keep_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !commit_p && !wr_mode |=> $stable(mode_q))
    else $error("mode changed without completed byte");
endmodule : acit_target

//--- bench/acit_host_model.sv
/*
 holds: behavioural serial bus master that drives the control target.
 assumes: bench resolves the data wire with a pull-up and feeds sda back.
*/
`timescale 1ns/1ps
module acit_host_model (
  input wire logic aclk,
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  // quarter of an SCL period: 4 x 160 aclk keeps the bus below 400kHz
  localparam int Q = 160;
  logic smp;
  // bus idles with both lines released high
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt
  // ****************************************
  // bus conditions and bits
  // ****************************************
  task automatic start();
    sda_m <= 1'b1;
    wt(Q);
    scl <= 1'b1;
    wt(Q);
    sda_m <= 1'b0;
    wt(Q);
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    wt(Q);
    sda_m <= 1'b0;
    wt(Q);
    scl <= 1'b1;
    wt(Q);
    sda_m <= 1'b1;
    wt(Q);
  endtask : stop
  // data changes only while scl is low, held through the high phase
  task automatic put_bit(input logic b);
    wt(Q);
    sda_m <= b;
    wt(Q);
    scl <= 1'b1;
    wt(Q);
    smp = sda;
    wt(Q);
    scl <= 1'b0;
  endtask : put_bit
  // msb first, then a released ninth slot whose level is the answer
  task automatic put_byte(input logic [7:0] v, output logic ack);
    for (int k = 7; k >= 0; k--) begin
      put_bit(v[k]);
    end
    put_bit(1'b1);
    ack = ~smp;
  endtask : put_byte
endmodule : acit_host_model

//--- bench/amp_control_i2c_target_tb.sv
/*
 holds: self-checking bench of the amplifier control target.
 assumes: acit_pkg, acit_map.svh and the host model are compiled first.
*/
`timescale 1ns/1ps
`include "acit_map.svh"
module amp_control_i2c_target_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic scl, sda_m, sda_w, sda_o, sda_oe_n, asel, isel, hp, beep;
  logic gx, va, mu, act, bo, so, a0, a1, a2;
  logic [4:0] vol;
  int fail_count, checks_done, cyc, mode_m, vol_m, ov, eb;
  // open-drain wire: a pull to 0 wins, else the pull-up; a driven 1 counts as released
  assign sda_w = ((sda_oe_n === 1'b0 && sda_o === 1'b0) || sda_m === 1'b0) ? 1'b0 : 1'b1;
  acit_target u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .address_select_pin(asel), .interface_select_pin(isel), .headphone_detect_pin(hp),
    .beep_detect_pin(beep), .gain_external(gx), .volume_adjustable(va), .audio_mute(mu),
    .device_active(act), .volume_level(vol), .bridged_output(bo),
    .single_ended_output(so));
  acit_host_model u_host (.aclk(aclk), .sda(sda_w), .scl(scl), .sda_m(sda_m));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic give_verdict();
    if (fail_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // valids held until their own ready, response awaited with bready up
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    logic ta, tw;
    ta = 0;
    tw = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) begin ta = 1; awvalid <= 1'b0; end
      if (wready === 1'b1) begin tw = 1; wvalid <= 1'b0; end
    end while (!(ta && tw));
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd
  // model against the control outputs
  task automatic cmp_out();
    chk({28'h0, gx, va, mu, act}, mode_m & 15);
    chk({27'h0, vol}, vol_m);
  endtask : cmp_out
  task automatic do_reset(input logic s);
    aresetn <= 1'b0;
    isel <= s;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    mode_m = 0;
    vol_m = 0;
  endtask : do_reset
  // hang guard, well above the expected run length
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fail_count++;
      give_verdict();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    {aresetn, isel, hp, beep} = 4'h0;
    {fail_count, checks_done, cyc} = 0;
    void'($urandom(32'h444C7DB0));
    asel = $urandom % 2;
    do_reset(1'b0);
    axi_rd(`ACIT_OFS_MODE);
    chk(d, 0);
    axi_rd(`ACIT_OFS_VOL);
    chk(d, 0);
    axi_rd(`ACIT_OFS_CTRL);
    chk(d, 1);
    axi_rd(`ACIT_OFS_STAT);
    chk(d, 1 | (asel << 3));
    axi_rd(4'h6);
    chk({30'h0, r}, `ACIT_RESP_SLVERR);
    axi_wr(4'h6, 32'h1F);
    chk({30'h0, r}, `ACIT_RESP_SLVERR);
    // mode and volume bytes in one transfer
    mode_m = $urandom % 16;
    vol_m = $urandom % 32;
    u_host.start();
    u_host.put_byte({`ACIT_ADDR_PREFIX, asel, 1'b0}, a0);
    u_host.put_byte(mode_m[7:0], a1);
    u_host.put_byte(8'h80 | vol_m[7:0], a2);
    chk({29'h0, a0, a1, a2}, 7);
    // repeated start, then a byte of no known prefix: acked and dropped
    u_host.start();
    u_host.put_byte({`ACIT_ADDR_PREFIX, asel, 1'b0}, a0);
    u_host.put_byte(8'h5F, a1);
    u_host.stop();
    chk({30'h0, a0, a1}, 3);
    cmp_out();
    // other strap address is not ours
    u_host.start();
    u_host.put_byte({`ACIT_ADDR_PREFIX, ~asel, 1'b0}, a0);
    u_host.stop();
    chk({31'h0, a0}, 0);
    // byte cut short by a stop leaves settings alone
    u_host.start();
    u_host.put_byte({`ACIT_ADDR_PREFIX, asel, 1'b0}, a0);
    u_host.put_bit(1'b0);
    u_host.put_bit(1'b0);
    u_host.put_bit(1'b0);
    u_host.put_bit(1'b1);
    u_host.stop();
    cmp_out();
    axi_rd(`ACIT_OFS_STAT);
    chk(d[5], 0);
    // target disabled through its enable bit
    axi_wr(`ACIT_OFS_CTRL, 32'h0);
    chk({30'h0, r}, `ACIT_RESP_OKAY);
    u_host.start();
    u_host.put_byte({`ACIT_ADDR_PREFIX, asel, 1'b0}, a0);
    u_host.stop();
    chk({31'h0, a0}, 0);
    axi_wr(`ACIT_OFS_CTRL, 32'h1);
    // every sense, override and beep combination
    for (int i = 0; i < 8; i++) begin
      ov = i % 2;
      axi_wr(`ACIT_OFS_MODE, mode_m | (ov << 4));
      hp <= i[1];
      beep <= i[2];
      repeat (8) @(posedge aclk);
      eb = i[2] | (!i[1] && !ov);
      chk({30'h0, bo, so}, eb ? 2 : 1);
      cmp_out();
    end
    // second reset with the strap selecting the other protocol
    do_reset(1'b1);
    cmp_out();
    axi_rd(`ACIT_OFS_STAT);
    chk(d & 32'h18, 16 | (asel << 3));
    u_host.start();
    u_host.put_byte({`ACIT_ADDR_PREFIX, asel, 1'b0}, a0);
    u_host.stop();
    chk({31'h0, a0}, 0);
    give_verdict();
  end
endmodule : amp_control_i2c_target_tb
